// ---- core/pma_field_add.sv ----
// Purpose: adder with a programmable carry chain, used for add and compare
// Assumes: carry_en bit i lets the carry from bit i into bit i+1
// Notes:   carry out of the top bit goes no further than cout[PIX_W-1]; per-bit carry out is returned
module pma_field_add
    import pma_pkg::*;
(
    input  wire logic [PIX_W-1:0] a,
    input  wire logic [PIX_W-1:0] b,
    input  wire logic [PIX_W-1:0] cin,
    input  wire logic [CCM_W-1:0] carry_en,
    output logic      [PIX_W-1:0] sum,
    output logic      [PIX_W-1:0] cout
);

    logic [PIX_W:0] c;

    assign c[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < PIX_W; i++) begin : g_bit
            logic ci;
            // Field base bits take their own carry-in, others the chained carry
            if (i == 0) begin : g_lo
                assign ci = cin[0];
            end else begin : g_hi
                assign ci = carry_en[i-1] ? c[i] : cin[i];
            end
            assign sum[i]  = a[i] ^ b[i] ^ ci;
            assign cout[i] = (a[i] & b[i]) | (ci & (a[i] ^ b[i]));
            assign c[i+1]  = cout[i];
        end
    endgenerate

endmodule : pma_field_add

// ---- core/pma_pixel_mix_alu.sv ----
// Purpose: per-pixel source/pattern select, logic and saturating mixes, masks
// Assumes: one pixel per clock; inputs synchronous; result registered
// Notes:   unused high pixel bits are treated as absent and read back as dst
module pma_pixel_mix_alu
    import pma_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              pix_valid,
    input  wire pma_pix_in_t       pix_in,
    input  wire pma_cfg_t          cfg,
    input  wire logic [PIX_W-1:0]  cmp_value,
    output pma_pix_out_t           pix_out,
    output logic                   pix_out_valid,
    output logic                   cmp_gt,
    output logic                   cmp_eq,
    output logic                   cmp_lt
);

    // Active bit lanes for a pixel size
    function automatic logic [PIX_W-1:0] lane_mask(input logic [1:0] bpp);
        logic [PIX_W-1:0] m;
        m = 8'h00;
        unique case (bpp)
            BPP_1: m = 8'h01;
            BPP_2: m = 8'h03;
            BPP_4: m = 8'h0f;
            BPP_8: m = 8'hff;
        endcase
        return m;
    endfunction : lane_mask

    // Per-field saturate: a field is a run of bits joined by the carry chain
    function automatic logic [PIX_W-1:0] field_fill(
        input logic [PIX_W-1:0] top_flag,
        input logic [CCM_W-1:0] joined);
        logic [PIX_W-1:0] f;
        f = top_flag;
        for (int k = PIX_W - 2; k >= 0; k--) begin
            if (joined[k]) begin
                f[k] = f[k+1];
            end
        end
        return f;
    endfunction : field_fill

    logic [PIX_W-1:0] lanes;
    logic [PIX_W-1:0] act;
    logic [CCM_W-1:0] chain;
    logic [PIX_W-1:0] field_top;
    logic             pattern;
    logic [7:0]       mix;
    logic [PIX_W-1:0] s;
    logic [PIX_W-1:0] d;
    logic [PIX_W-1:0] add_sum;
    logic [PIX_W-1:0] add_co;
    logic [PIX_W-1:0] sds_sum;
    logic [PIX_W-1:0] sds_co;
    logic [PIX_W-1:0] ssd_sum;
    logic [PIX_W-1:0] ssd_co;
    logic [PIX_W-1:0] cmp_sum;
    logic [PIX_W-1:0] cmp_co;
    logic [PIX_W-1:0] sd_ge;
    logic [PIX_W-1:0] cd_ge;
    logic [PIX_W-1:0] mix_res;
    logic [PIX_W-1:0] new_pix;
    logic             wr_en;
    logic [PIX_W-1:0] lsb_of_field;

    assign lanes = lane_mask(cfg.bpp);
    // Masked-out bits take no part in any arithmetic or compare
    assign act   = lanes & cfg.bit_mask;
    // Carry chain cut at pixel edge; higher mask bits ignored
    // Masked bits stay inside their field as zeros, so a full chain keeps one field
    assign chain = cfg.carry_mask & lanes[PIX_W-1:1];

    // Top bit of each field, used to read each field's carry/borrow
    always_comb begin
        field_top = lanes;
        for (int k = 0; k < CCM_W; k++) begin
            if (chain[k]) begin
                field_top[k] = 1'b0;
            end
        end
    end

    always_comb begin
        lsb_of_field = lanes;
        for (int k = 1; k < PIX_W; k++) begin
            if (chain[k-1]) begin
                lsb_of_field[k] = 1'b0;
            end
        end
    end

    // Pattern source
    always_comb begin
        unique case (cfg.pat_sel)
            PAT_MAP_A: pattern = pix_in.pat_a;
            PAT_MAP_B: pattern = pix_in.pat_b;
            PAT_MAP_C: pattern = pix_in.pat_c;
            PAT_ONE:   pattern = 1'b1;
            PAT_SRC:   pattern = |(pix_in.src & lanes);
            default:   pattern = 1'b1;
        endcase
    end

    // Pattern selects source and mix; fixed colours act as 2-entry table
    always_comb begin
        if (pattern) begin
            s   = cfg.fg_from_map ? pix_in.src : cfg.fg_color;
            mix = cfg.foreground_function;
        end else begin
            s   = cfg.bg_from_map ? pix_in.src : cfg.bg_color;
            mix = cfg.background_function;
        end
    end

    assign d = pix_in.dst & act;

    // Three adders share the carry chain: add, d-s, s-d
    pma_field_add u_add (
        .a        (s & act),
        .b        (d),
        .cin      ({PIX_W{1'b0}}),
        .carry_en (chain),
        .sum      (add_sum),
        .cout     (add_co)
    );

    pma_field_add u_sub_ds (
        .a        (d),
        .b        (~(s & act) & lanes),
        .cin      (lsb_of_field),
        .carry_en (chain),
        .sum      (sds_sum),
        .cout     (sds_co)
    );

    pma_field_add u_sub_sd (
        .a        (s & act),
        .b        (~d & lanes),
        .cin      (lsb_of_field),
        .carry_en (chain),
        .sum      (ssd_sum),
        .cout     (ssd_co)
    );

    // Compare of destination against compare value, same field split
    pma_field_add u_cmp (
        .a        (d),
        .b        (~(cmp_value & act) & lanes),
        .cin      (lsb_of_field),
        .carry_en (chain),
        .sum      (cmp_sum),
        .cout     (cmp_co)
    );

    // Per-field "first >= second" flag spread across each field
    assign sd_ge = field_fill(ssd_co & field_top, chain);
    assign cd_ge = field_fill(cmp_co & field_top, chain);

    always_comb begin
        logic [PIX_W-1:0] ov;
        logic [PIX_W-1:0] ds_ok;
        ov    = field_fill(add_co & field_top, chain);
        ds_ok = field_fill(sds_co & field_top, chain);
        unique case (mix)
            MIX_ZERO:     mix_res = 8'h00;
            MIX_AND:      mix_res = s & d;
            MIX_S_AND_ND: mix_res = s & ~d;
            MIX_SRC:      mix_res = s;
            MIX_NS_AND_D: mix_res = ~s & d;
            MIX_DST:      mix_res = d;
            MIX_XOR:      mix_res = s ^ d;
            MIX_OR:       mix_res = s | d;
            MIX_NOR:      mix_res = ~s & ~d;
            MIX_XNOR:     mix_res = s ^ ~d;
            MIX_NDST:     mix_res = ~d;
            MIX_S_OR_ND:  mix_res = s | ~d;
            MIX_NSRC:     mix_res = ~s;
            MIX_NS_OR_D:  mix_res = ~s | d;
            MIX_NAND:     mix_res = ~s | ~d;
            MIX_ONES:     mix_res = 8'hff;
            MIX_MAX:      mix_res = (sd_ge & s) | (~sd_ge & d);
            MIX_MIN:      mix_res = (sd_ge & d) | (~sd_ge & s);
            MIX_ADDS:     mix_res = add_sum | ov;
            MIX_SUBDS:    mix_res = sds_sum & ds_ok;
            MIX_SUBSD:    mix_res = ssd_sum & sd_ge;
            // Carry out lands in top bit, so shifting it in halves the sum
            MIX_AVG:      mix_res = ({ov[PIX_W-1], add_sum[PIX_W-1:1]} & ~field_top)
                                    | (ov & field_top & act);
            // Reserved codes are software's to avoid; keep dst
            default:      mix_res = d;
        endcase
    end

    // Write-enabled bits take the mix result; others keep old dst
    assign wr_en   = !cfg.mask_en || pix_in.mask;
    assign new_pix = wr_en ? ((mix_res & act) | (pix_in.dst & ~act)) : pix_in.dst;

    pma_pix_out_t out_d, out_q;
    logic         vld_d, vld_q;
    logic         gt_d, eq_d, lt_d, gt_q, eq_q, lt_q;

    always_comb begin
        out_d.pix     = pix_valid ? new_pix : out_q.pix;
        out_d.written = pix_valid && wr_en;
        vld_d         = pix_valid;
        eq_d          = pix_valid ? ((d ^ (cmp_value & act)) == 8'h00) : eq_q;
        gt_d          = pix_valid ? ((|(cd_ge & field_top)) && !eq_d) : gt_q;
        lt_d          = pix_valid ? (!gt_d && !eq_d) : lt_q;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= '{pix: RST_PIX, written: 1'b0};
            vld_q <= 1'b0;
            gt_q  <= 1'b0;
            eq_q  <= 1'b0;
            lt_q  <= 1'b0;
        end else begin
            out_q <= out_d;
            vld_q <= vld_d;
            gt_q  <= gt_d;
            eq_q  <= eq_d;
            lt_q  <= lt_d;
        end
    end

    assign pix_out       = out_q;
    assign pix_out_valid = vld_q;
    assign cmp_gt        = gt_q;
    assign cmp_eq        = eq_q;
    assign cmp_lt        = lt_q;

endmodule : pma_pixel_mix_alu

// ---- pkg/pma_pkg.sv ----
// Purpose: shared types and constants of the pixel mix datapath
// Assumes: pixels of 1, 2, 4 or 8 bits, unsigned, in the low bits of a byte
// Notes:   mix codes 0x16..0xff are undefined; the datapath returns dst for them
package pma_pkg;

    localparam int unsigned PIX_W  = 8;
    localparam int unsigned CCM_W  = PIX_W - 1;

    // Pixel size selector
    localparam logic [1:0] BPP_1 = 2'h0;
    localparam logic [1:0] BPP_2 = 2'h1;
    localparam logic [1:0] BPP_4 = 2'h2;
    localparam logic [1:0] BPP_8 = 2'h3;

    // Pattern source selector
    localparam logic [2:0] PAT_MAP_A = 3'h0;
    localparam logic [2:0] PAT_MAP_B = 3'h1;
    localparam logic [2:0] PAT_MAP_C = 3'h2;
    localparam logic [2:0] PAT_ONE   = 3'h3;
    localparam logic [2:0] PAT_SRC   = 3'h4;

    // Mix codes
    localparam logic [7:0] MIX_ZERO    = 8'h00;
    localparam logic [7:0] MIX_AND     = 8'h01;
    localparam logic [7:0] MIX_S_AND_ND = 8'h02;
    localparam logic [7:0] MIX_SRC     = 8'h03;
    localparam logic [7:0] MIX_NS_AND_D = 8'h04;
    localparam logic [7:0] MIX_DST     = 8'h05;
    localparam logic [7:0] MIX_XOR     = 8'h06;
    localparam logic [7:0] MIX_OR      = 8'h07;
    localparam logic [7:0] MIX_NOR     = 8'h08;
    localparam logic [7:0] MIX_XNOR    = 8'h09;
    localparam logic [7:0] MIX_NDST    = 8'h0a;
    localparam logic [7:0] MIX_S_OR_ND = 8'h0b;
    localparam logic [7:0] MIX_NSRC    = 8'h0c;
    localparam logic [7:0] MIX_NS_OR_D = 8'h0d;
    localparam logic [7:0] MIX_NAND    = 8'h0e;
    localparam logic [7:0] MIX_ONES    = 8'h0f;
    localparam logic [7:0] MIX_MAX     = 8'h10;
    localparam logic [7:0] MIX_MIN     = 8'h11;
    localparam logic [7:0] MIX_ADDS    = 8'h12;
    localparam logic [7:0] MIX_SUBDS   = 8'h13;
    localparam logic [7:0] MIX_SUBSD   = 8'h14;
    localparam logic [7:0] MIX_AVG     = 8'h15;

    // Reset values of output registers
    localparam logic [PIX_W-1:0] RST_PIX = 8'h00;

    // Per-pixel input bundle
    typedef struct packed {
        logic [PIX_W-1:0] src;
        logic [PIX_W-1:0] dst;
        logic             pat_a;
        logic             pat_b;
        logic             pat_c;
        logic             mask;
    } pma_pix_in_t;

    // Operation-wide configuration
    typedef struct packed {
        logic [1:0]       bpp;
        logic [2:0]       pat_sel;
        logic             fg_from_map;
        logic             bg_from_map;
        logic [7:0]       foreground_function;
        logic [7:0]       background_function;
        logic [PIX_W-1:0] fg_color;
        logic [PIX_W-1:0] bg_color;
        logic [CCM_W-1:0] carry_mask;
        logic [PIX_W-1:0] bit_mask;
        logic             mask_en;
    } pma_cfg_t;

    typedef struct packed {
        logic [PIX_W-1:0] pix;
        logic             written;
    } pma_pix_out_t;

endpackage : pma_pkg

// ---- tb/pma_pixel_mix_alu_asserts.sv ----
// Purpose: port-level checks of the pixel mix datapath
// Assumes: result registered one cycle after pix_valid
// Notes:   keep marks bits that must return the old destination value
module pma_pixel_mix_alu_asserts
    import pma_pkg::*;
(
    input wire logic             clock,
    input wire logic             reset_n,
    input wire logic             pix_valid,
    input wire pma_pix_in_t      pix_in,
    input wire pma_cfg_t         cfg,
    input wire logic [PIX_W-1:0] cmp_value,
    input wire pma_pix_out_t     pix_out,
    input wire logic             pix_out_valid,
    input wire logic             cmp_gt,
    input wire logic             cmp_eq,
    input wire logic             cmp_lt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PIX_W-1:0] keep;
    logic             plain;
    assign keep  = ~(cfg.bit_mask & (8'hff >> (4'h8 - (4'h1 << cfg.bpp))));
    assign plain = pix_valid && !cfg.mask_en;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_answer_next: assert property (pix_valid |=> pix_out_valid) else $error("no result");
    a_idle_hold: assert property (!pix_valid |=> !pix_out_valid && !pix_out.written
        && $stable(pix_out.pix))
        else $error("output moved while idle");
    a_mask_keeps: assert property (pix_valid && cfg.mask_en && !pix_in.mask |=>
        !pix_out.written && pix_out.pix == $past(pix_in.dst)) else $error("mask 0 wrote");
    a_mask_writes: assert property (pix_valid && (!cfg.mask_en || pix_in.mask) |=>
        pix_out.written) else $error("mask 1 blocked");
    a_bits_kept: assert property (pix_valid |=> ((pix_out.pix ^ $past(pix_in.dst))
        & $past(keep)) == 8'h00) else $error("protected bit changed");
    a_zeros_mix: assert property (plain && cfg.foreground_function == MIX_ZERO &&
        cfg.background_function == MIX_ZERO |=> pix_out.pix == ($past(pix_in.dst)
        & $past(keep))) else $error("zeros mix wrong");
    a_ones_mix: assert property (plain && cfg.foreground_function == MIX_ONES &&
        cfg.background_function == MIX_ONES |=> pix_out.pix == ($past(pix_in.dst)
        | ~$past(keep))) else $error("ones mix wrong");
    a_forced_fg: assert property (plain && cfg.pat_sel == PAT_ONE && !cfg.fg_from_map &&
        cfg.foreground_function == MIX_SRC |=> pix_out.pix == (($past(cfg.fg_color) &
        ~$past(keep)) | ($past(pix_in.dst) & $past(keep)))) else $error("fg force wrong");
    a_cmp_onehot: assert property (pix_out_valid |-> $onehot({cmp_gt, cmp_eq, cmp_lt}))
        else $error("compare flags not one-hot");
endmodule : pma_pixel_mix_alu_asserts

bind pma_pixel_mix_alu pma_pixel_mix_alu_asserts i_chk (.clock(clock), .reset_n(reset_n),
    .pix_valid(pix_valid), .pix_in(pix_in), .cfg(cfg), .cmp_value(cmp_value),
    .pix_out(pix_out), .pix_out_valid(pix_out_valid), .cmp_gt(cmp_gt), .cmp_eq(cmp_eq),
    .cmp_lt(cmp_lt));

// ---- tb/pma_pixel_mix_alu_tb.sv ----
// Purpose: self-checking bench of the pixel mix datapath, pixels from a memory model
// Assumes: one result per pixel, one cycle later; back-to-back pixels
// Notes:   compare flags are checked only with a full carry chain, so field-split compare is never checked
module pma_pixel_mix_alu_tb;
    import pma_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] pix; logic wr; logic [2:0] cmp; logic ok;} pma_exp_t;
    logic         clock = 1'b0;
    logic         reset_n = 1'b0;
    logic         pix_valid = 1'b0;
    logic         ld_en = 1'b0;
    logic [5:0]   ld_addr = 6'h00;
    logic [5:0]   addr = 6'h00;
    pma_pix_in_t  ld_pix = '0;
    pma_pix_in_t  pix_in;
    pma_cfg_t     cfg = '0;
    logic [7:0]   cmp_value = 8'h00;
    pma_pix_out_t pix_out;
    logic         pix_out_valid, cmp_gt, cmp_eq, cmp_lt;
    pma_pix_in_t  img [64];
    pma_exp_t     exp_q [$];
    int           miscompares = 0, n_compared = 0, cycles = 0, tests = 0;
    always #4 clock = ~clock;
    pma_pixel_mix_alu i_dut (.clock(clock), .reset_n(reset_n), .pix_valid(pix_valid),
        .pix_in(pix_in), .cfg(cfg), .cmp_value(cmp_value), .pix_out(pix_out),
        .pix_out_valid(pix_out_valid), .cmp_gt(cmp_gt), .cmp_eq(cmp_eq), .cmp_lt(cmp_lt));
    pma_vmem i_mem (.clock(clock), .ld_en(ld_en), .ld_addr(ld_addr), .ld_pix(ld_pix),
        .rd_en(pix_valid), .rd_addr(addr), .rd_pix(pix_in), .wb_pix(pix_out),
        .wb_valid(pix_out_valid));
    function automatic pma_exp_t model(pma_pix_in_t p, pma_cfg_t c, logic [7:0] cv);
        int w, lo, a, b, r, lim;
        logic [7:0] act, s, d, res;
        logic pat;
        logic [7:0] op;
        pma_exp_t e;
        w = 1 << c.bpp;
        act = c.bit_mask & (8'hff >> (8 - w));
        case (c.pat_sel)
            PAT_MAP_A: pat = p.pat_a;
            PAT_MAP_B: pat = p.pat_b;
            PAT_MAP_C: pat = p.pat_c;
            PAT_SRC:   pat = (p.src & (8'hff >> (8 - w))) != 8'h00;
            default:   pat = 1'b1;
        endcase
        s = pat ? (c.fg_from_map ? p.src : c.fg_color) : (c.bg_from_map ? p.src : c.bg_color);
        op = pat ? c.foreground_function : c.background_function;
        d = p.dst;
        res = 8'h00;
        if (op < 8'h10) begin
            res = ({8{op[0]}} & s & d) | ({8{op[1]}} & s & ~d) | ({8{op[2]}} & ~s & d)
                | ({8{op[3]}} & ~s & ~d);
        end else begin
            lo = 0;
            for (int i = 0; i < w; i++) begin
                if (i == w - 1 || !c.carry_mask[i]) begin
                    lim = (1 << (i - lo + 1)) - 1;
                    a = (s & act) >> lo & lim;
                    b = (d & act) >> lo & lim;
                    case (op[2:0])
                        3'h0: r = a > b ? a : b;
                        3'h1: r = a < b ? a : b;
                        3'h2: r = a + b > lim ? lim : a + b;
                        3'h3: r = b > a ? b - a : 0;
                        3'h4: r = a > b ? a - b : 0;
                        default: r = (a + b) >> 1;
                    endcase
                    res = res | 8'(r << lo);
                    lo = i + 1;
                end
            end
        end
        e.wr = !(c.mask_en && !p.mask);
        e.pix = e.wr ? ((res & act) | (d & ~act)) : d;
        a = d & act;
        b = cv & act;
        e.cmp = {a > b, a == b, a < b};
        e.ok = &c.carry_mask;
        return e;
    endfunction : model
    task automatic cmp_val(logic [7:0] got, logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask : cmp_val
    task automatic cmp_flag(logic got, logic want);
        cmp_val({7'h00, got}, {7'h00, want});
    endtask : cmp_flag
    task automatic check();
        pma_exp_t e;
        if (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            cmp_flag(pix_out_valid, 1'b1);
            cmp_val(pix_out.pix, e.pix);
            cmp_flag(pix_out.written, e.wr);
            if (e.ok) begin
                cmp_val({5'h00, cmp_gt, cmp_eq, cmp_lt}, {5'h00, e.cmp});
            end
        end
    endtask : check
    task automatic run(pma_cfg_t c, int n);
        pma_exp_t e;
        for (int k = 0; k < n; k++) begin
            @(posedge clock);
            #1;
            check();
            addr = addr + 6'h01;
            cmp_value = 8'($urandom);
            cfg = c;
            pix_valid = 1'b1;
            e = model(img[addr], c, cmp_value);
            img[addr].dst = e.pix;
            exp_q.push_back(e);
        end
        @(posedge clock);
        #1;
        check();
        pix_valid = 1'b0;
        tests++;
        $display("test %0d done", tests);
    endtask : run
    function automatic pma_cfg_t rnd_cfg();
        pma_cfg_t c;
        c = pma_cfg_t'(55'({$urandom, $urandom}));
        c.pat_sel = 3'($urandom_range(4));
        c.foreground_function = 8'($urandom_range(21));
        c.background_function = 8'($urandom_range(21));
        // Average always gets a full carry chain here, so field-split average is never run
        if ($urandom_range(1) == 1 || c.foreground_function == MIX_AVG
            || c.background_function == MIX_AVG) begin
            c.carry_mask = 7'h7f;
        end
        return c;
    endfunction : rnd_cfg
    task automatic corner(logic [7:0] f, logic [7:0] b, logic [2:0] ps, logic [1:0] bp,
                          logic [6:0] cm, logic fm);
        pma_cfg_t c;
        c = rnd_cfg();
        c.foreground_function = f;
        c.background_function = b;
        c.pat_sel = ps;
        c.bpp = bp;
        c.carry_mask = cm;
        c.fg_from_map = fm;
        c.bg_from_map = fm;
        c.mask_en = 1'b0;
        run(c, 8);
    endtask : corner
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        void'($urandom(92));
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        for (int a = 0; a < 64; a++) begin
            img[a] = pma_pix_in_t'(20'($urandom));
            ld_en = 1'b1;
            ld_addr = 6'(a);
            ld_pix = img[a];
            @(posedge clock);
            #1;
        end
        ld_en = 1'b0;
        corner(MIX_ZERO, MIX_ZERO, PAT_MAP_A, BPP_8, 7'h7f, 1'b1);
        corner(MIX_ONES, MIX_ONES, PAT_SRC, BPP_2, 7'h00, 1'b1);
        corner(MIX_SRC, MIX_NSRC, PAT_ONE, BPP_4, 7'h7f, 1'b0);
        corner(MIX_SRC, MIX_SRC, PAT_MAP_B, BPP_8, 7'h7f, 1'b0);
        corner(MIX_ADDS, MIX_SUBDS, PAT_MAP_C, BPP_8, 7'h77, 1'b1);
        corner(MIX_SUBSD, MIX_MIN, PAT_SRC, BPP_4, 7'h57, 1'b1);
        corner(MIX_MAX, MIX_ADDS, PAT_MAP_A, BPP_1, 7'h00, 1'b1);
        repeat (40) run(rnd_cfg(), 10);
        results();
    end
endmodule : pma_pixel_mix_alu_tb

// ---- tb/pma_vmem.sv ----
// Purpose: video memory model holding source, pattern, mask and destination maps
// Assumes: one pixel bundle per address; reads are combinational
// Notes:   write-back lands one edge after the result, like a read-modify-write
module pma_vmem
    import pma_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         ld_en,
    input  wire logic [5:0]   ld_addr,
    input  wire pma_pix_in_t  ld_pix,
    input  wire logic         rd_en,
    input  wire logic [5:0]   rd_addr,
    output pma_pix_in_t       rd_pix,
    input  wire pma_pix_out_t wb_pix,
    input  wire logic         wb_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    pma_pix_in_t mem [64];
    logic [5:0]  wb_addr;
    always_ff @(posedge clock) begin
        if (ld_en) begin
            mem[ld_addr] <= ld_pix;
        end
        if (wb_valid && wb_pix.written) begin
            mem[wb_addr].dst <= wb_pix.pix;
        end
        if (rd_en) begin
            wb_addr <= rd_addr;
        end
    end
    // Idle reads toggle so stale data never looks like a valid pixel
    assign rd_pix = rd_en ? mem[rd_addr] : pma_pix_in_t'({5{rd_addr[3:0]}} ^ {20{clock}});
endmodule : pma_vmem
